// ===== dv/dif_field.sv
`default_nettype none
module dif_field (
  // Clock.
  input wire logic clk_in,
  // Pot and switch settings.
  input wire logic [35:0] lvl_in,
  input wire logic [5:0] sw_in,
  // Pins towards the block.
  output logic [11:0] volt_out = 12'h000,
  output logic [11:0] cur_out = 12'h000,
  output logic [11:0] aux_out = 12'h000,
  output logic [5:0] pin_out = 6'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pots and contacts move only just after an edge, never on it.
  always @(posedge clk_in) begin
    volt_out <= lvl_in[11:0];
    cur_out <= lvl_in[23:12];
    aux_out <= lvl_in[35:24];
    pin_out <= sw_in;
  end
endmodule : dif_field
`default_nettype wire

// ===== dv/dif_top_bench.sv
`default_nettype none
`define CK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module dif_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bry = 1'b0;
  logic arv = 1'b0;
  logic rry = 1'b0;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [35:0] lvl = 36'h0_0000_0000;
  logic [5:0] sw = 6'h00;
  logic awr, wrd, bv, arr, rv, rev, ign, hold, frst;
  logic [1:0] br, rr, acc;
  logic [31:0] rdd;
  logic [15:0] freq;
  logic [3:0] step;
  logic [11:0] av, ac, au;
  logic [5:0] pins;
  int miscompares = 0;
  int n_checks = 0;
  always #5 clk = ~clk;
  dif_field dif_field_inst (.clk_in(clk), .lvl_in(lvl), .sw_in(sw),
    .volt_out(av), .cur_out(ac), .aux_out(au), .pin_out(pins));
  // A short tick keeps the delay filter test within the run budget.
  dif_top #(.TICK_CYCLES(20)) dif_top_inst (.SYS_CLK_IN(clk),
    .RESETN_IN(rst_n), .AWVALID_IN(awv), .AWREADY_OUT(awr),
    .AWADDR_IN(awa), .WVALID_IN(wv), .WREADY_OUT(wrd), .WDATA_IN(wd),
    .WSTRB_IN(4'hF), .BVALID_OUT(bv), .BREADY_IN(bry), .BRESP_OUT(br),
    .ARVALID_IN(arv), .ARREADY_OUT(arr), .ARADDR_IN(ara),
    .RVALID_OUT(rv), .RREADY_IN(rry), .RDATA_OUT(rdd), .RRESP_OUT(rr),
    .ANALOG_VOLTAGE_INPUT_IN(av), .ANALOG_CURRENT_INPUT_IN(ac),
    .ANALOG_AUX_INPUT_IN(au), .DIGITAL_INPUT_IN(pins),
    .FREQ_CMD_OUT(freq), .DIR_REV_OUT(rev), .EXT_DIR_IGNORE_OUT(ign),
    .STEP_SEL_OUT(step), .ACCEL_SEL_OUT(acc), .ACCEL_HOLD_OUT(hold),
    .FAULT_RESET_OUT(frst));
  task automatic summarize();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awv === 1'b1 && awr === 1'b1) awv <= 1'b0;
      if (wv === 1'b1 && wrd === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1);
    r = br;
    bry <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      if (arv === 1'b1 && arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rdd;
    r = rr;
    rry <= 1'b0;
  endtask : rd
  task automatic wok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    `CK(r, dif_pkg::RESP_OKAY)
  endtask : wok
  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CK(d, e)
  endtask : chk
  task automatic pin(input logic [5:0] v);
    @(posedge clk);
    sw <= v;
    repeat (10) @(posedge clk);
  endtask : pin
  task automatic ana(input logic [35:0] v, input int n);
    @(posedge clk);
    lvl <= v;
    repeat (n) @(posedge clk);
  endtask : ana
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    summarize();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int p;
    int ef[3];
    int ea[3];
    ef = '{0, 3000, 0};
    ea = '{3000, 1464, 5998};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    chk(dif_pkg::OFS_CTRL, dif_pkg::RST_CTRL);
    chk(dif_pkg::OFS_CODES, dif_pkg::RST_CODES);
    chk(dif_pkg::OFS_DLY0 + 8'h08, dif_pkg::RST_DLY);
    chk(dif_pkg::OFS_CFG0 + 8'h04, dif_pkg::RST_CFG);
    rd(8'hF0, d, r);
    `CK(r, dif_pkg::RESP_SLVERR)
    wr(8'hF4, 32'h0000_0001, r);
    `CK(r, dif_pkg::RESP_SLVERR)
    $display("test registers done");
    pin(6'b101010);
    `CK(step, 4'hA)
    `CK(hold, 1'b1)
    `CK(frst, 1'b0)
    @(posedge clk);
    sw <= 6'b111010;
    p = 0;
    repeat (20) begin
      @(posedge clk);
      if (frst === 1'b1) p++;
    end
    `CK(p, 1)
    chk(dif_pkg::OFS_STATUS, 32'h00A0_0000);
    // Unused terminals go to the no-function code.
    wok(dif_pkg::OFS_CODES, 32'h0000_0107);
    pin(6'h3F);
    `CK(acc, 2'h3)
    `CK(step, 4'h0)
    `CK(hold, 1'b0)
    pin(6'h01);
    `CK(acc, 2'h1)
    pin(6'h00);
    `CK(acc, 2'h0)
    wok(dif_pkg::OFS_CODES, 32'h0000_0000);
    pin(6'h3F);
    `CK(step, 4'h0)
    `CK(acc, 2'h0)
    `CK(hold, 1'b0)
    pin(6'h00);
    wok(dif_pkg::OFS_CODES, dif_pkg::RST_CODES);
    $display("test terminals done");
    wok(dif_pkg::OFS_CFG0, 32'h0190_1388);
    wok(dif_pkg::OFS_DFREQ, 32'h0000_04D2);
    wok(dif_pkg::OFS_CTRL, 32'h0000_0000);
    ana(36'hFFF_3E8_800, 300);
    `CK(freq, 16'h04D2)
    `CK(rev, 1'b0)
    wok(dif_pkg::OFS_CFG0, dif_pkg::RST_CFG);
    for (int i = 0; i < 3; i++) begin
      wok(dif_pkg::OFS_CTRL, 32'(i + 1));
      repeat (300) @(posedge clk);
      `CK(freq, 16'(ea[i]))
    end
    wok(dif_pkg::OFS_CFG0 + 8'h08, 32'h0190_0000);
    repeat (300) @(posedge clk);
    `CK(freq, dif_pkg::RST_FMAX[15:0])
    wok(dif_pkg::OFS_CTRL, 32'h0000_0006);
    repeat (300) @(posedge clk);
    `CK(freq, 16'd1460)
    $display("test scaling done");
    wok(dif_pkg::OFS_CTRL, 32'h0000_0001);
    ana(36'h0, 10);
    for (int m = 0; m < 3; m++) begin
      wok(dif_pkg::OFS_CFG0, 32'h00C9_1388 | (m << 25));
      repeat (300) @(posedge clk);
      `CK(freq, 16'(ef[m]))
      `CK(rev, m == 1)
      `CK(ign, m == 1)
    end
    wok(dif_pkg::OFS_CFG0, 32'h02C9_1388);
    ana(36'h800, 300);
    `CK(freq, 16'd0)
    wok(dif_pkg::OFS_CFG0, 32'h08C8_2710);
    repeat (300) @(posedge clk);
    `CK(freq, 16'd3000)
    `CK(rev, 1'b1)
    ana(36'hFFF, 300);
    `CK(freq, 16'd2)
    `CK(rev, 1'b1)
    $display("test polarity done");
    wok(dif_pkg::OFS_CFG0, dif_pkg::RST_CFG);
    wok(dif_pkg::OFS_DLY0, 32'd100);
    ana(36'h400, 0);
    p = 0;
    while (freq !== 16'd1500 && p < 5000) begin
      @(posedge clk);
      p++;
    end
    // The next reload comes 101 ticks of 20 cycles after this one.
    ana(36'h800, 1500);
    `CK(freq, 16'd1500)
    repeat (600) @(posedge clk);
    `CK(freq, 16'd3000)
    $display("test delay done");
    summarize();
  end
endmodule : dif_top_bench
`default_nettype wire

// ===== src/dif_chan.sv
`default_nettype none
module dif_chan #(
  parameter int ADC_W = 12,
  parameter int DLY_W = 10
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Delay step enable.
  input wire logic tick_in,
  // Sample and settings.
  input wire logic [ADC_W-1:0] sample_in,
  input wire logic [15:0] bias_in,
  input wire logic bias_neg_in,
  input wire logic [7:0] gain_in,
  input wire logic [1:0] neg_mode_in,
  input wire logic slope_neg_in,
  input wire logic [DLY_W-1:0] delay_in,
  input wire logic [15:0] fmax_in,
  // Result.
  output logic [15:0] freq_out,
  output logic rev_out,
  output logic bidir_out
);
  localparam int FULL_DIV = (1 << ADC_W) * dif_pkg::GAIN_DIV;
  logic [ADC_W-1:0] held_q;
  logic [DLY_W-1:0] cnt_q;
  logic [15:0] freq_q;
  logic rev_q;
  logic bidir_q;
  wire [63:0] span_full = 64'(held_q) * 64'(gain_in) * 64'(fmax_in)
    / 64'(FULL_DIV);
  wire [63:0] bias_full = 64'(fmax_in) * 64'(bias_in)
    / 64'(dif_pkg::BIAS_DIV);
  wire signed [20:0] span_s = $signed({1'b0, span_full[19:0]});
  wire signed [20:0] bias_s = $signed({1'b0, bias_full[19:0]});
  wire signed [20:0] val = (slope_neg_in ? -span_s : span_s)
    + (bias_neg_in ? -bias_s : bias_s);
  wire is_neg = val[20];
  wire rev_mode = (neg_mode_in == dif_pkg::NEG_REV_EN) && !slope_neg_in;
  wire [20:0] mag = is_neg ? (rev_mode ? 21'(-val) : 21'h0) : 21'(val);
  wire [15:0] sat = (mag > 21'(fmax_in)) ? fmax_in : mag[15:0];
  wire load = (delay_in == '0) || (tick_in && cnt_q >= delay_in);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      held_q <= '0;
      cnt_q <= '0;
    end else if (load) begin
      held_q <= sample_in;
      cnt_q <= '0;
    end else if (tick_in) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      freq_q <= '0;
      rev_q <= 1'b0;
      bidir_q <= 1'b0;
    end else begin
      freq_q <= sat;
      rev_q <= slope_neg_in || (rev_mode && is_neg);
      bidir_q <= rev_mode;
    end
  end

  assign freq_out = freq_q;
  assign rev_out = rev_q;
  assign bidir_out = bidir_q;

  a_neg_clamp: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (neg_mode_in != dif_pkg::NEG_REV_EN && !slope_neg_in && is_neg)
    |=> (freq_q == 16'h0000 && !rev_q))
    else $error("negative command not clamped to zero");
  a_slope_rev: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    slope_neg_in |=> rev_q && !bidir_q)
    else $error("negative slope not reverse only");
  a_delay_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!tick_in && delay_in != '0) |=> $stable(held_q))
    else $error("filtered sample moved between delay steps");
  a_sat_limit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    1'b1 |=> freq_q <= $past(fmax_in))
    else $error("frequency above maximum");
endmodule : dif_chan
`default_nettype wire

// ===== src/dif_pkg.sv
// Operation
// - Negative bias selector: 00 none, 01 reverse enabled, 02 reverse disabled.
// - Bias, polarity, gain and negative bias act only with an analog source.
// - Scaled analog frequency saturates at the maximum output frequency.
// - Bidirectional reverse-enabled input gives zero at mid-scale, ignores FWD/REV.
// - Negative slope: larger signal gives lower frequency, reverse direction only.
// - Each analog input has its own delay filter, 0.01 s steps, default 0.05 s.
// - Analog frequency command quantised: 00 gives 0.01Hz, 01 gives 0.1Hz.
// - Six digital terminals with own codes, defaults 01 to 06.
// - Function code 00 has no effect; unused terminals should use it.
// - Codes 01 to 04 select among 16 step-speed frequencies.
// - Code 05 is a normally-open external reset, like the keypad reset.
// - Code 06 active halts accel/decel and holds the present speed.
// - Codes 07 and 08 select one of four accel/decel time pairs.
`default_nettype none
package dif_pkg;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FMAX = 8'h04;
  localparam logic [7:0] OFS_DFREQ = 8'h08;
  localparam logic [7:0] OFS_CODES = 8'h0C;
  localparam logic [7:0] OFS_CFG0 = 8'h10;
  localparam logic [7:0] OFS_DLY0 = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_RES_BIT = 2;
  localparam int CFG_POL_BIT = 16;
  localparam int CFG_GAIN_LSB = 17;
  localparam int CFG_NEG_LSB = 25;
  localparam int CFG_SLOPE_BIT = 27;
  localparam int CODE_W = 5;
  localparam logic [31:0] RST_CTRL = 32'h0000_0004;
  localparam logic [31:0] RST_FMAX = 32'h0000_1770;
  localparam logic [31:0] RST_CODES = 32'h0C52_0C41;
  localparam logic [31:0] RST_CFG = 32'h00C8_0000;
  localparam logic [31:0] RST_DLY = 32'h0000_0005;
  localparam logic [31:0] MASK_CTRL = 32'h0000_0007;
  localparam logic [31:0] MASK_CFG = 32'h0FFF_FFFF;
  localparam logic [31:0] MASK_DLY = 32'h0000_03FF;
  localparam logic [31:0] MASK_CODES = 32'h3FFF_FFFF;
  localparam logic [31:0] MASK_16 = 32'h0000_FFFF;
  localparam logic [1:0] NEG_NONE = 2'h0;
  localparam logic [1:0] NEG_REV_EN = 2'h1;
  localparam logic [1:0] NEG_REV_DIS = 2'h2;
  localparam logic [1:0] SRC_DIGITAL = 2'h0;
  localparam logic [4:0] FN_NONE = 5'h00;
  localparam logic [4:0] FN_STEP1 = 5'h01;
  localparam logic [4:0] FN_RESET = 5'h05;
  localparam logic [4:0] FN_HOLD = 5'h06;
  localparam logic [4:0] FN_ACC1 = 5'h07;
  localparam logic [4:0] FN_ACC2 = 5'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DELAY_STEP_NS = 10_000_000;
  localparam int DELAY_TICK_CYCLES = DELAY_STEP_NS / CLK_PERIOD_NS;
  localparam int DELAY_MAX_STEPS = 1000;
  localparam int GAIN_DIV = 100;
  localparam int BIAS_DIV = 10000;
  localparam int QUANT_COARSE = 10;
endpackage : dif_pkg
`default_nettype wire

// ===== src/dif_top.sv
// Added by the designer: the AXI4-Lite register port and the register addresses.
`default_nettype none
module dif_top #(
  parameter int ADC_W = 12,
  parameter int TICK_CYCLES = dif_pkg::DELAY_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic SYS_CLK_IN,
  input wire logic RESETN_IN,
  // AXI4-Lite write address and data.
  input wire logic AWVALID_IN,
  output logic AWREADY_OUT,
  input wire logic [7:0] AWADDR_IN,
  input wire logic WVALID_IN,
  output logic WREADY_OUT,
  input wire logic [31:0] WDATA_IN,
  input wire logic [3:0] WSTRB_IN,
  // AXI4-Lite write response.
  output logic BVALID_OUT,
  input wire logic BREADY_IN,
  output logic [1:0] BRESP_OUT,
  // AXI4-Lite read.
  input wire logic ARVALID_IN,
  output logic ARREADY_OUT,
  input wire logic [7:0] ARADDR_IN,
  output logic RVALID_OUT,
  input wire logic RREADY_IN,
  output logic [31:0] RDATA_OUT,
  output logic [1:0] RRESP_OUT,
  // Analog samples and digital terminal pins.
  input wire logic [ADC_W-1:0] ANALOG_VOLTAGE_INPUT_IN,
  input wire logic [ADC_W-1:0] ANALOG_CURRENT_INPUT_IN,
  input wire logic [ADC_W-1:0] ANALOG_AUX_INPUT_IN,
  input wire logic [5:0] DIGITAL_INPUT_IN,
  // Drive commands.
  output logic [15:0] FREQ_CMD_OUT,
  output logic DIR_REV_OUT,
  output logic EXT_DIR_IGNORE_OUT,
  output logic [3:0] STEP_SEL_OUT,
  output logic [1:0] ACCEL_SEL_OUT,
  output logic ACCEL_HOLD_OUT,
  output logic FAULT_RESET_OUT
);
  localparam int NT = 6;
  localparam int CW = dif_pkg::CODE_W;
  localparam int TW = $clog2(TICK_CYCLES + 1);

  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, wdata_q;
  logic [7:0] awaddr_q;
  logic [3:0] wstrb_q;
  logic [31:0] ctrl_q, fmax_q, dfreq_q, codes_q;
  logic [31:0] cfg_q [3];
  logic [31:0] dly_q [3];
  logic [TW-1:0] div_q;
  logic tick_q;
  logic [3*ADC_W-1:0] an_s1_q, an_s2_q, an_s3_q, an_q;
  logic [NT-1:0] t_s1_q, t_s2_q, t_s3_q, term_q;
  logic [15:0] freq_q;
  logic rev_q, ign_q, hold_q, frst_q, rst_lvl_q;
  logic [3:0] step_q;
  logic [1:0] acc_q;

  // Write channel: address and data taken in either order.
  wire aw_take = AWVALID_IN && awready_q;
  wire w_take = WVALID_IN && wready_q;
  wire do_write = !awready_q && !wready_q && !bvalid_q;
  wire b_done = bvalid_q && BREADY_IN;
  wire ar_take = ARVALID_IN && arready_q;
  wire r_done = rvalid_q && RREADY_IN;
  wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
    {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  // Address decode of the held write address.
  wire [7:0] wa = awaddr_q;
  wire wr_ctrl = wa == dif_pkg::OFS_CTRL;
  wire wr_fmax = wa == dif_pkg::OFS_FMAX;
  wire wr_dfreq = wa == dif_pkg::OFS_DFREQ;
  wire wr_codes = wa == dif_pkg::OFS_CODES;
  wire [7:0] wcfg_i = (wa - dif_pkg::OFS_CFG0) >> 2;
  wire [7:0] wdly_i = (wa - dif_pkg::OFS_DLY0) >> 2;
  wire wr_cfg = wa >= dif_pkg::OFS_CFG0 && wa < dif_pkg::OFS_DLY0
    && wa[1:0] == 2'h0;
  wire wr_dly = wa >= dif_pkg::OFS_DLY0 && wa < dif_pkg::OFS_STATUS
    && wa[1:0] == 2'h0;
  wire wr_ok = wr_ctrl || wr_fmax || wr_dfreq || wr_codes || wr_cfg
    || wr_dly;

  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= dif_pkg::RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_take) begin
        awready_q <= 1'b0;
        awaddr_q <= AWADDR_IN;
      end
      if (w_take) begin
        wready_q <= 1'b0;
        wdata_q <= WDATA_IN;
        wstrb_q <= WSTRB_IN;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? dif_pkg::RESP_OKAY : dif_pkg::RESP_SLVERR;
      end
      if (b_done) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Settings registers, merged byte by byte under the write strobes.
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ctrl_q <= dif_pkg::RST_CTRL;
      fmax_q <= dif_pkg::RST_FMAX;
      dfreq_q <= 32'h0000_0000;
      codes_q <= dif_pkg::RST_CODES;
      for (int i = 0; i < 3; i++) begin
        cfg_q[i] <= dif_pkg::RST_CFG;
        dly_q[i] <= dif_pkg::RST_DLY;
      end
    end else if (do_write) begin
      if (wr_ctrl) ctrl_q <= ((ctrl_q & ~wmask) | (wdata_q & wmask))
        & dif_pkg::MASK_CTRL;
      if (wr_fmax) fmax_q <= ((fmax_q & ~wmask) | (wdata_q & wmask))
        & dif_pkg::MASK_16;
      if (wr_dfreq) dfreq_q <= ((dfreq_q & ~wmask) | (wdata_q & wmask))
        & dif_pkg::MASK_16;
      if (wr_codes) codes_q <= ((codes_q & ~wmask) | (wdata_q & wmask))
        & dif_pkg::MASK_CODES;
      if (wr_cfg) cfg_q[wcfg_i[1:0]] <= ((cfg_q[wcfg_i[1:0]] & ~wmask)
        | (wdata_q & wmask)) & dif_pkg::MASK_CFG;
      if (wr_dly) dly_q[wdly_i[1:0]] <= ((dly_q[wdly_i[1:0]] & ~wmask)
        | (wdata_q & wmask)) & dif_pkg::MASK_DLY;
    end
  end

  // Read decode straight from the address channel.
  wire [7:0] ra = ARADDR_IN;
  wire [7:0] rcfg_i = (ra - dif_pkg::OFS_CFG0) >> 2;
  wire [7:0] rdly_i = (ra - dif_pkg::OFS_DLY0) >> 2;
  wire rd_cfg = ra >= dif_pkg::OFS_CFG0 && ra < dif_pkg::OFS_DLY0
    && ra[1:0] == 2'h0;
  wire rd_dly = ra >= dif_pkg::OFS_DLY0 && ra < dif_pkg::OFS_STATUS
    && ra[1:0] == 2'h0;
  wire [31:0] status = {8'h00, step_q, acc_q, ign_q, rev_q, freq_q};
  wire rd_hit = ra == dif_pkg::OFS_CTRL || ra == dif_pkg::OFS_FMAX
    || ra == dif_pkg::OFS_DFREQ || ra == dif_pkg::OFS_CODES || rd_cfg
    || rd_dly || ra == dif_pkg::OFS_STATUS;
  wire [31:0] rd_val =
    ra == dif_pkg::OFS_CTRL ? ctrl_q :
    ra == dif_pkg::OFS_FMAX ? fmax_q :
    ra == dif_pkg::OFS_DFREQ ? dfreq_q :
    ra == dif_pkg::OFS_CODES ? codes_q :
    rd_cfg ? cfg_q[rcfg_i[1:0]] :
    rd_dly ? dly_q[rdly_i[1:0]] :
    ra == dif_pkg::OFS_STATUS ? status : 32'h0000_0000;

  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= dif_pkg::RESP_OKAY;
    end else if (ar_take) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_hit ? dif_pkg::RESP_OKAY : dif_pkg::RESP_SLVERR;
    end else if (r_done) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Delay step divider, one enable pulse per 0.01 s.
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= div_q == TW'(TICK_CYCLES - 1);
      div_q <= (div_q == TW'(TICK_CYCLES - 1)) ? '0 : div_q + 1'b1;
    end
  end

  // Pin synchronisers; a value is accepted once stages two and three agree.
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      an_s1_q <= '0;
      an_s2_q <= '0;
      an_s3_q <= '0;
      an_q <= '0;
      t_s1_q <= '0;
      t_s2_q <= '0;
      t_s3_q <= '0;
      term_q <= '0;
    end else begin
      an_s1_q <= {ANALOG_AUX_INPUT_IN, ANALOG_CURRENT_INPUT_IN,
        ANALOG_VOLTAGE_INPUT_IN};
      an_s2_q <= an_s1_q;
      an_s3_q <= an_s2_q;
      if (an_s2_q == an_s3_q) an_q <= an_s3_q;
      t_s1_q <= DIGITAL_INPUT_IN;
      t_s2_q <= t_s1_q;
      t_s3_q <= t_s2_q;
      if (t_s2_q == t_s3_q) term_q <= t_s3_q;
    end
  end

  // Analog channels.
  wire [15:0] ch_freq [3];
  wire [2:0] ch_rev;
  wire [2:0] ch_bidir;
  genvar g;
  for (g = 0; g < 3; g++) begin : g_chan
    dif_chan #(.ADC_W(ADC_W), .DLY_W(10)) u_chan (
      .clk_in(SYS_CLK_IN),
      .rst_n_in(RESETN_IN),
      .tick_in(tick_q),
      .sample_in(an_q[g*ADC_W +: ADC_W]),
      .bias_in(cfg_q[g][15:0]),
      .bias_neg_in(cfg_q[g][dif_pkg::CFG_POL_BIT]),
      .gain_in(cfg_q[g][dif_pkg::CFG_GAIN_LSB +: 8]),
      .neg_mode_in(cfg_q[g][dif_pkg::CFG_NEG_LSB +: 2]),
      .slope_neg_in(cfg_q[g][dif_pkg::CFG_SLOPE_BIT]),
      .delay_in(dly_q[g][9:0]),
      .fmax_in(fmax_q[15:0]),
      .freq_out(ch_freq[g]),
      .rev_out(ch_rev[g]),
      .bidir_out(ch_bidir[g])
    );
  end

  wire [1:0] src = ctrl_q[dif_pkg::CTRL_SRC_LSB +: 2];
  wire analog = src != dif_pkg::SRC_DIGITAL;
  wire [1:0] ci = src - 2'h1;
  wire [15:0] a_f = (ci == 2'h3) ? 16'h0000 : ch_freq[ci];
  wire coarse = ctrl_q[dif_pkg::CTRL_RES_BIT];
  wire [15:0] a_q = coarse ? a_f - 16'(a_f % dif_pkg::QUANT_COARSE) : a_f;
  wire [15:0] f_next = analog ? a_q : dfreq_q[15:0];
  wire rev_next = analog && ci != 2'h3 && ch_rev[ci];
  wire ign_next = analog && ci != 2'h3 && ch_bidir[ci];

  // Terminal function decode; code 00 matches nothing.
  logic [3:0] step_d;
  logic [1:0] acc_d;
  logic hold_d, rst_lvl_d;
  always_comb begin
    step_d = 4'h0;
    acc_d = 2'h0;
    hold_d = 1'b0;
    rst_lvl_d = 1'b0;
    for (int i = 0; i < NT; i++) begin
      if (term_q[i] && codes_q[i*CW +: CW] != dif_pkg::FN_NONE) begin
        for (int k = 0; k < 4; k++) begin
          if (codes_q[i*CW +: CW] == dif_pkg::FN_STEP1 + 5'(k)) begin
            step_d[k] = 1'b1;
          end
        end
        if (codes_q[i*CW +: CW] == dif_pkg::FN_ACC1) acc_d[0] = 1'b1;
        if (codes_q[i*CW +: CW] == dif_pkg::FN_ACC2) acc_d[1] = 1'b1;
        if (codes_q[i*CW +: CW] == dif_pkg::FN_HOLD) hold_d = 1'b1;
        if (codes_q[i*CW +: CW] == dif_pkg::FN_RESET) rst_lvl_d = 1'b1;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      freq_q <= 16'h0000;
      rev_q <= 1'b0;
      ign_q <= 1'b0;
      step_q <= 4'h0;
      acc_q <= 2'h0;
      hold_q <= 1'b0;
      rst_lvl_q <= 1'b0;
      frst_q <= 1'b0;
    end else begin
      freq_q <= f_next;
      rev_q <= rev_next;
      ign_q <= ign_next;
      step_q <= step_d;
      acc_q <= acc_d;
      hold_q <= hold_d;
      rst_lvl_q <= rst_lvl_d;
      frst_q <= rst_lvl_d && !rst_lvl_q;
    end
  end

  // The reset output is a pulse, so a held contact clears a fault only once.
  assign AWREADY_OUT = awready_q;
  assign WREADY_OUT = wready_q;
  assign BVALID_OUT = bvalid_q;
  assign BRESP_OUT = bresp_q;
  assign ARREADY_OUT = arready_q;
  assign RVALID_OUT = rvalid_q;
  assign RDATA_OUT = rdata_q;
  assign RRESP_OUT = rresp_q;
  assign FREQ_CMD_OUT = freq_q;
  assign DIR_REV_OUT = rev_q;
  assign EXT_DIR_IGNORE_OUT = ign_q;
  assign STEP_SEL_OUT = step_q;
  assign ACCEL_SEL_OUT = acc_q;
  assign ACCEL_HOLD_OUT = hold_q;
  assign FAULT_RESET_OUT = frst_q;

  a_digital_src: assert property (@(posedge SYS_CLK_IN)
    disable iff (!RESETN_IN)
    !analog |=> freq_q == $past(dfreq_q[15:0]) && !rev_q)
    else $error("digital source not passed through");
  a_quant_step: assert property (@(posedge SYS_CLK_IN)
    disable iff (!RESETN_IN)
    (analog && coarse) |=> freq_q % 16'h000A == 16'h0000)
    else $error("coarse resolution not applied");
  a_reset_pulse: assert property (@(posedge SYS_CLK_IN)
    disable iff (!RESETN_IN)
    frst_q |=> !frst_q)
    else $error("external reset longer than one cycle");
  a_hold_follow: assert property (@(posedge SYS_CLK_IN)
    disable iff (!RESETN_IN)
    (term_q[5] && codes_q[29:25] == dif_pkg::FN_HOLD) |=> hold_q)
    else $error("accel hold not raised");
  a_none_code: assert property (@(posedge SYS_CLK_IN)
    disable iff (!RESETN_IN)
    (codes_q == 32'h0000_0000) |=> (step_q == 4'h0 && acc_q == 2'h0
      && !hold_q && !frst_q))
    else $error("unused terminal had an effect");
  a_step_zero: assert property (@(posedge SYS_CLK_IN)
    disable iff (!RESETN_IN)
    (term_q == 6'h00) |=> step_q == 4'h0 && acc_q == 2'h0)
    else $error("idle terminals gave a nonzero index");
endmodule : dif_top
`default_nettype wire
